// ---- verilog/rtcm_pkg.sv ----
// Constants and types shared by the real-time clock core
package rtcm_pkg;

   // ***************************************************************
   // Widths and clocking
   // ***************************************************************
   localparam int TIMER_W       = 32;
   localparam int CNT_W         = 24;
   localparam int CLK_PERIOD_NS = 20;

   // ***************************************************************
   // Timing figures, in their own units
   // ***************************************************************
   localparam int MCD_TIME_US   = 100;
   localparam int XVLD_BLANK_MS = 2;

   // Least time in ns to whole clock cycles, rounded up, at least one
   function automatic int rtcm_cycles_up(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : rtcm_cycles_up

   localparam int MCD_CYCLES  = rtcm_cycles_up(MCD_TIME_US * 1000);
   localparam int XVLD_CYCLES = rtcm_cycles_up(XVLD_BLANK_MS * 1000000);

   // ***************************************************************
   // Control vector field positions
   // ***************************************************************
   localparam int CTL_W         = 8;
   localparam int CTL_MCD_EN    = 6;
   localparam int CTL_RUN       = 4;
   localparam int CTL_AUTO_RST  = 2;
   localparam logic [CTL_W-1:0] CTL_RST_VAL = 8'h00;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [TIMER_W-1:0] TIMER_RST_VAL = 32'h00000000;
   localparam logic [CNT_W-1:0]   CNT_RST_VAL   = 24'h000000;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SET,
      ST_CAP
   } rtcm_state_t;

   // Where an event is sent: interrupt, wake-up, device reset
   typedef struct packed {
      logic irq;
      logic wake;
      logic rst;
   } rtcm_route_t;

   localparam rtcm_route_t ROUTE_NONE = 3'h0;

endpackage : rtcm_pkg

// ---- verilog/rtcm_core.sv ----
// Real-time clock core: timer, alarm, auto-reset, clock monitors
//
// How it works
// - Detector enabled and oscillator stuck beyond 100 us sets the fail flag.
// - A detector timeout is routed to interrupt, wake-up or reset requests.
// - Crystal-valid output is forced invalid for 2 ms after crystal turn-on.
// - 32-bit timer counts each oscillator cycle while run bit is 1.
// - Alarm match is routed to interrupt, wake-up or reset requests.
// - With auto-reset, timer clears one oscillator cycle after alarm falls.
// - Control bit 2 set to 1 enables the auto-reset behaviour.
// - Timer is set or read through holding registers without stopping.
// - Set strobe copies holding registers into timer, then strobe clears.
// - Capture strobe copies timer into holding registers, then clears.
`timescale 1ns/10ps

module rtcm_core #(
   parameter logic [23:0] MCD_LIMIT  = 24'(rtcm_pkg::MCD_CYCLES),
   parameter logic [23:0] XVLD_LIMIT = 24'(rtcm_pkg::XVLD_CYCLES)
) (
   input  wire logic                                mclk,
   input  wire logic                                rstn,
   input  wire logic                                rtc_osc,
   input  wire logic [rtcm_pkg::CTL_W-1:0]          rtc_control_reg,
   input  wire logic [rtcm_pkg::TIMER_W-1:0]        alarm_value,
   input  wire logic                                hold_wr,
   input  wire logic [rtcm_pkg::TIMER_W-1:0]        hold_wdata,
   input  wire logic                                set_req,
   input  wire logic                                cap_req,
   input  wire logic                                osc_fail_clear,
   input  wire logic                                crystal_osc_enable,
   input  wire logic                                crystal_amplitude_ok,
   input  wire rtcm_pkg::rtcm_route_t               alarm_route,
   input  wire rtcm_pkg::rtcm_route_t               mcd_route,
   output logic [rtcm_pkg::TIMER_W-1:0]             capture_holding_regs,
   output logic                                     timer_set_strobe,
   output logic                                     timer_capture_strobe,
   output logic                                     oscillator_fail_flag,
   output logic                                     crystal_valid_indicator,
   output logic                                     alarm_active,
   output rtcm_pkg::rtcm_route_t                    alarm_req,
   output rtcm_pkg::rtcm_route_t                    mcd_req
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   rtcm_pkg::rtcm_state_t               state;
   rtcm_pkg::rtcm_state_t               next_state;
   logic                                osc_prev;
   logic [rtcm_pkg::TIMER_W-1:0]        timer;
   logic [rtcm_pkg::TIMER_W-1:0]        next_timer;
   logic [rtcm_pkg::TIMER_W-1:0]        next_hold;
   logic                                arst_pend;
   logic                                next_arst_pend;
   logic [rtcm_pkg::CNT_W-1:0]          stall_cnt;
   logic [rtcm_pkg::CNT_W-1:0]          next_stall_cnt;
   logic [rtcm_pkg::CNT_W-1:0]          blank_cnt;
   logic [rtcm_pkg::CNT_W-1:0]          next_blank_cnt;
   logic                                next_fail;
   wire                                 osc_edge;
   wire                                 osc_rise;
   wire                                 run_en;
   wire                                 auto_rst_en;
   wire                                 mcd_en;
   wire                                 set_now;
   wire                                 cap_now;
   wire                                 arst_now;
   wire                                 alarm_match;
   wire                                 alarm_fall;
   wire                                 alarm_rise;
   wire                                 fail_set;
   wire                                 blank_done;
   wire                                 stall_park;

   // ***************************************************************
   // Decoding
   // ***************************************************************
   assign run_en      = rtc_control_reg[rtcm_pkg::CTL_RUN];
   assign auto_rst_en = rtc_control_reg[rtcm_pkg::CTL_AUTO_RST];
   assign mcd_en      = rtc_control_reg[rtcm_pkg::CTL_MCD_EN];
   assign osc_edge    = rtc_osc ^ osc_prev;
   assign osc_rise    = rtc_osc & ~osc_prev;
   assign set_now     = (state == rtcm_pkg::ST_SET);
   assign cap_now     = (state == rtcm_pkg::ST_CAP);
   assign alarm_match = (timer == alarm_value);
   assign alarm_rise  = alarm_match & ~alarm_active;
   assign alarm_fall  = alarm_active & ~alarm_match;
   assign arst_now    = arst_pend & osc_rise;
   assign fail_set    = mcd_en & (stall_cnt == MCD_LIMIT);
   assign stall_park  = (stall_cnt == MCD_LIMIT + 24'h000001);
   assign blank_done  = (blank_cnt == XVLD_LIMIT);

   // ***************************************************************
   // Timer next value
   // ***************************************************************
   // Setting wins over auto-reset, which wins over counting
   assign next_timer = set_now  ? capture_holding_regs :
                       arst_now ? rtcm_pkg::TIMER_RST_VAL :
                       (run_en & osc_rise) ?
                       timer + 32'h00000001 : timer;

   // A new alarm fall re-arms the pending clear even as it fires
   assign next_arst_pend = (alarm_fall & auto_rst_en) |
                           (arst_pend & ~arst_now & ~set_now &
                            auto_rst_en);

   // Capture overrides a software write in the same cycle
   assign next_hold = cap_now ? timer :
                      hold_wr ? hold_wdata : capture_holding_regs;

   // ***************************************************************
   // Strobe sequencing
   // ***************************************************************
   always_comb begin
      case (state)
         rtcm_pkg::ST_IDLE: begin
            if (set_req) begin
               next_state = rtcm_pkg::ST_SET;
            end else if (cap_req) begin
               next_state = rtcm_pkg::ST_CAP;
            end else begin
               next_state = rtcm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = rtcm_pkg::ST_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // Missing-clock detector and crystal blanking counters
   // ***************************************************************
   // Clearing the flag restarts the stall count so the detector re-arms;
   // the count parks one past the limit so a timeout fires only once
   assign next_stall_cnt = (!mcd_en || osc_edge || osc_fail_clear) ?
                           rtcm_pkg::CNT_RST_VAL :
                           stall_park ? stall_cnt :
                           stall_cnt + 24'h000001;

   // Set wins over clear
   assign next_fail = fail_set |
                      (oscillator_fail_flag & ~osc_fail_clear);

   assign next_blank_cnt = !crystal_osc_enable ? rtcm_pkg::CNT_RST_VAL :
                           blank_done ? blank_cnt :
                           blank_cnt + 24'h000001;

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state                <= rtcm_pkg::ST_IDLE;
         osc_prev             <= 1'b0;
         timer                <= rtcm_pkg::TIMER_RST_VAL;
         capture_holding_regs <= rtcm_pkg::TIMER_RST_VAL;
         arst_pend            <= 1'b0;
         alarm_active         <= 1'b0;
      end else begin
         state                <= next_state;
         osc_prev             <= rtc_osc;
         timer                <= next_timer;
         capture_holding_regs <= next_hold;
         arst_pend            <= next_arst_pend;
         alarm_active         <= alarm_match;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timer_set_strobe     <= 1'b0;
         timer_capture_strobe <= 1'b0;
      end else begin
         timer_set_strobe     <= (next_state == rtcm_pkg::ST_SET);
         timer_capture_strobe <= (next_state == rtcm_pkg::ST_CAP);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stall_cnt               <= rtcm_pkg::CNT_RST_VAL;
         oscillator_fail_flag    <= 1'b0;
         blank_cnt               <= rtcm_pkg::CNT_RST_VAL;
         crystal_valid_indicator <= 1'b0;
      end else begin
         stall_cnt               <= next_stall_cnt;
         oscillator_fail_flag    <= next_fail;
         blank_cnt               <= next_blank_cnt;
         crystal_valid_indicator <= crystal_osc_enable & blank_done &
                                    crystal_amplitude_ok;
      end
   end

   // Event requests are one-cycle pulses on the rising event
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         alarm_req <= rtcm_pkg::ROUTE_NONE;
         mcd_req   <= rtcm_pkg::ROUTE_NONE;
      end else begin
         alarm_req <= alarm_route & {3{alarm_rise}};
         mcd_req   <= mcd_route &
                      {3{fail_set & ~oscillator_fail_flag}};
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence stall_reached_s;
      mcd_en && stall_cnt == MCD_LIMIT;
   endsequence

   sequence alarm_drop_s;
      alarm_fall && auto_rst_en && !set_now;
   endsequence

   osc_fail_set_a: assert property (
      stall_reached_s |=> oscillator_fail_flag)
      else $error("fail flag not set after stall timeout");

   fail_sticky_a: assert property (
      oscillator_fail_flag && !osc_fail_clear |=> oscillator_fail_flag)
      else $error("fail flag dropped without a clear");

   fail_rearm_a: assert property (
      osc_fail_clear |=> stall_cnt == 24'h000000)
      else $error("clear did not restart the stall count");

   mcd_route_a: assert property (
      $rose(oscillator_fail_flag) |-> mcd_req == $past(mcd_route))
      else $error("missing-clock request does not follow route");

   timer_count_a: assert property (
      run_en && osc_rise && !set_now && !arst_now
      |=> timer == $past(timer) + 32'h00000001)
      else $error("timer did not advance on oscillator cycle");

   timer_hold_a: assert property (
      !osc_rise && !set_now |=> $stable(timer))
      else $error("timer moved without an oscillator cycle");

   auto_reset_a: assert property (
      alarm_drop_s ##1 (!osc_rise && !set_now)[*4] ##1
      (osc_rise && !set_now) |=> timer == 32'h00000000)
      else $error("auto-reset did not clear timer");

   no_auto_reset_a: assert property (
      !auto_rst_en |=> !arst_pend)
      else $error("auto-reset armed while disabled");

   set_done_a: assert property (
      state == rtcm_pkg::ST_IDLE && set_req
      |=> timer_set_strobe ##1 (!timer_set_strobe &&
      timer == $past(capture_holding_regs)))
      else $error("set strobe did not load the timer");

   capture_done_a: assert property (
      state == rtcm_pkg::ST_IDLE && cap_req && !set_req
      |=> timer_capture_strobe ##1 (!timer_capture_strobe &&
      capture_holding_regs == $past(timer)))
      else $error("capture strobe did not snapshot the timer");

   xvld_blank_a: assert property (
      !blank_done |=> !crystal_valid_indicator)
      else $error("crystal-valid shown inside blanking interval");

   alarm_route_a: assert property (
      alarm_match && !alarm_active |=> alarm_req == $past(alarm_route))
      else $error("alarm request does not follow route");

endmodule : rtcm_core

// ---- verification/rtcm_tb.sv ----
// Self-checking testbench for the real-time clock core
`timescale 1ns/10ps

module tb;
   // ***************************************************************
   // Signals
   // ***************************************************************
   logic                              mclk;
   logic                              rstn;
   logic                              rtc_osc;
   logic [rtcm_pkg::CTL_W-1:0]        ctl;
   logic [rtcm_pkg::TIMER_W-1:0]      alarm_value;
   logic                              hold_wr;
   logic [rtcm_pkg::TIMER_W-1:0]      hold_wdata;
   logic                              set_req;
   logic                              cap_req;
   logic                              osc_fail_clear;
   logic                              xtal_en;
   logic                              xtal_amp_ok;
   rtcm_pkg::rtcm_route_t             alarm_route;
   rtcm_pkg::rtcm_route_t             mcd_route;
   logic [rtcm_pkg::TIMER_W-1:0]      capture_holding_regs;
   logic                              timer_set_strobe;
   logic                              timer_capture_strobe;
   logic                              oscillator_fail_flag;
   logic                              crystal_valid_indicator;
   logic                              alarm_active;
   rtcm_pkg::rtcm_route_t             alarm_req;
   rtcm_pkg::rtcm_route_t             mcd_req;
   rtcm_pkg::rtcm_route_t             alarm_seen;
   rtcm_pkg::rtcm_route_t             mcd_seen;
   logic [31:0]                       seed;
   logic [31:0]                       a;
   int                                checks;
   int                                mismatches;
   int                                cycles;

   rtcm_core #(
      .MCD_LIMIT  (24'h000014),
      .XVLD_LIMIT (24'h000032)
   ) rtcm_core_inst (
      .mclk                    (mclk),
      .rstn                    (rstn),
      .rtc_osc                 (rtc_osc),
      .rtc_control_reg         (ctl),
      .alarm_value             (alarm_value),
      .hold_wr                 (hold_wr),
      .hold_wdata              (hold_wdata),
      .set_req                 (set_req),
      .cap_req                 (cap_req),
      .osc_fail_clear          (osc_fail_clear),
      .crystal_osc_enable      (xtal_en),
      .crystal_amplitude_ok    (xtal_amp_ok),
      .alarm_route             (alarm_route),
      .mcd_route               (mcd_route),
      .capture_holding_regs    (capture_holding_regs),
      .timer_set_strobe        (timer_set_strobe),
      .timer_capture_strobe    (timer_capture_strobe),
      .oscillator_fail_flag    (oscillator_fail_flag),
      .crystal_valid_indicator (crystal_valid_indicator),
      .alarm_active            (alarm_active),
      .alarm_req               (alarm_req),
      .mcd_req                 (mcd_req)
   );

   // ***************************************************************
   // Clock, event capture and hang limit
   // ***************************************************************
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   always @(posedge mclk) begin
      alarm_seen <= alarm_seen | alarm_req;
      mcd_seen <= mcd_seen | mcd_req;
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Timer two oscillator rises after the match
   function automatic logic [31:0] after_alarm(input logic auto_rst,
                                               input logic [31:0] m);
      return auto_rst ? 32'h00000000 : m + 32'h00000002;
   endfunction : after_alarm

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic osc_pulse();
      rtc_osc = 1'b1;
      tick(3);
      rtc_osc = 1'b0;
      tick(3);
   endtask : osc_pulse

   // Raise a strobe request and count how long the strobe stands
   task automatic strobe(input logic do_set);
      int hi;
      hi = 0;
      if (do_set) set_req = 1'b1;
      else cap_req = 1'b1;
      tick(1);
      set_req = 1'b0;
      cap_req = 1'b0;
      repeat (4) begin
         if ((do_set ? timer_set_strobe : timer_capture_strobe) === 1'b1) hi++;
         tick(1);
      end
      chk("strobe_cycles", 32'(hi), 32'h00000001);
   endtask : strobe

   task automatic load(input logic [31:0] v);
      hold_wr = 1'b1;
      hold_wdata = v;
      tick(1);
      hold_wr = 1'b0;
      strobe(1'b1);
   endtask : load

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      {rstn, rtc_osc, ctl, alarm_value, hold_wr, hold_wdata} = '0;
      {set_req, cap_req, osc_fail_clear, xtal_en, xtal_amp_ok} = '0;
      {alarm_route, mcd_route, alarm_seen, mcd_seen} = '0;
      {checks, mismatches, cycles} = '0;
      seed = 32'h0000ee19;
      tick(5);
      rstn = 1'b1;
      tick(1);
      chk("fail_flag_rst", 32'(oscillator_fail_flag), 32'h0);
      chk("holding_rst", capture_holding_regs, 32'h0);
      // Set, run, capture, then stop and capture again
      seed = lfsr(seed);
      ctl[rtcm_pkg::CTL_RUN] = 1'b1;
      load(seed);
      repeat (3) osc_pulse();
      strobe(1'b0);
      chk("timer_run", capture_holding_regs, seed + 32'h3);
      ctl[rtcm_pkg::CTL_RUN] = 1'b0;
      repeat (2) osc_pulse();
      strobe(1'b0);
      chk("timer_hold", capture_holding_regs, seed + 32'h3);
      // Alarm with every route code, auto-reset on odd passes
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         a = seed | 32'h00000010;
         alarm_value = a;
         alarm_route = 3'(i);
         ctl = '0;
         ctl[rtcm_pkg::CTL_RUN] = 1'b1;
         ctl[rtcm_pkg::CTL_AUTO_RST] = i[0];
         load(a - 32'h1);
         alarm_seen = '0;
         osc_pulse();
         chk("alarm_active", 32'(alarm_active), 32'h1);
         chk("alarm_req", 32'(alarm_seen), 32'(i));
         repeat (2) osc_pulse();
         strobe(1'b0);
         chk("auto_reset", capture_holding_regs,
             after_alarm(i[0], a));
      end
      // Missing clock: disabled, toggling, stalled, cleared and re-armed
      ctl = '0;
      tick(40);
      chk("mcd_off", 32'(oscillator_fail_flag), 32'h0);
      seed = lfsr(seed);
      mcd_route = seed[2:0] | 3'h1;
      mcd_seen = '0;
      ctl[rtcm_pkg::CTL_MCD_EN] = 1'b1;
      repeat (8) osc_pulse();
      chk("mcd_toggle", 32'(oscillator_fail_flag), 32'h0);
      tick(26);
      chk("mcd_stall", 32'(oscillator_fail_flag), 32'h1);
      chk("mcd_req", 32'(mcd_seen), 32'(mcd_route));
      tick(20);
      chk("mcd_sticky", 32'(oscillator_fail_flag), 32'h1);
      osc_fail_clear = 1'b1;
      tick(1);
      osc_fail_clear = 1'b0;
      chk("mcd_clear", 32'(oscillator_fail_flag), 32'h0);
      tick(26);
      chk("mcd_rearm", 32'(oscillator_fail_flag), 32'h1);
      ctl = '0;
      // Crystal valid blanking after turn-on
      xtal_amp_ok = 1'b1;
      xtal_en = 1'b1;
      tick(40);
      chk("xtal_blank", 32'(crystal_valid_indicator), 32'h0);
      tick(20);
      chk("xtal_valid", 32'(crystal_valid_indicator), 32'h1);
      xtal_amp_ok = 1'b0;
      tick(3);
      chk("xtal_lost", 32'(crystal_valid_indicator), 32'h0);
      stop_test();
   end
endmodule : tb
